// [psrc_ctrl.sv]
// Peripheral soft reset controller with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "psrc_regs.svh"

module psrc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`PSRC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PSRC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] capability_mask_first,
  input wire logic [31:0] capability_mask_second,
  output psrc_pkg::psrc_resets_t periph_reset
);

  // ****************************************
  // Write channel capture
  // ****************************************
  logic aw_held_r;
  logic w_held_r;
  logic [`PSRC_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [31:0] ctrl_first_r;
  logic [31:0] ctrl_second_r;
  logic [31:0] ctrl_first_nxt;
  logic [31:0] ctrl_second_nxt;
  logic [31:0] wr_en_first;
  logic [31:0] wr_en_second;
  logic wr_hit_first;
  logic wr_hit_second;
  logic wr_hit_any;
  logic rd_hit_first;
  logic rd_hit_second;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  // ****************************************
  // Register map constants
  // ****************************************
  localparam logic [`PSRC_ADDR_W-1:0] OFS_FIRST = `PSRC_OFS_CTRL_FIRST;
  localparam logic [`PSRC_ADDR_W-1:0] OFS_SECOND = `PSRC_OFS_CTRL_SECOND;
  localparam logic [31:0] DEF_FIRST = `PSRC_DEF_FIRST;
  localparam logic [31:0] DEF_SECOND = `PSRC_DEF_SECOND;

  // ****************************************
  // Write handshakes
  // ****************************************
  // A new write is refused while the last response still waits
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  // Address and data may arrive in either order; the write waits for both
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // ****************************************
  // Write address holding
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  // ****************************************
  // Write data holding
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Word address compare; the two low address bits are ignored
  assign wr_hit_first = awaddr_r[`PSRC_ADDR_W-1:2] == OFS_FIRST[`PSRC_ADDR_W-1:2];
  assign wr_hit_second = awaddr_r[`PSRC_ADDR_W-1:2] == OFS_SECOND[`PSRC_ADDR_W-1:2];
  assign wr_hit_any = wr_hit_first || wr_hit_second;

  // ****************************************
  // Per-bit write enables
  // ****************************************
  // A bit takes new data only when addressed, strobed, present and defined;
  // reserved bits are never enabled, so they stay at their reset value of zero
  for (genvar b = 0; b < 32; b++) begin : g_bit
    assign wr_en_first[b] = wr_hit_first && wstrb_r[b / 8] &&
      capability_mask_first[b] && DEF_FIRST[b];
    assign wr_en_second[b] = wr_hit_second && wstrb_r[b / 8] &&
      capability_mask_second[b] && DEF_SECOND[b];
    assign ctrl_first_nxt[b] = wr_en_first[b] ? wdata_r[b] : ctrl_first_r[b];
    assign ctrl_second_nxt[b] = wr_en_second[b] ? wdata_r[b] : ctrl_second_r[b];
  end

  // ****************************************
  // First control register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_first_r <= `PSRC_RST_CTRL;
    end else if (do_write) begin
      ctrl_first_r <= ctrl_first_nxt;
    end
  end

  // ****************************************
  // Second control register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_second_r <= `PSRC_RST_CTRL;
    end else if (do_write) begin
      ctrl_second_r <= ctrl_second_nxt;
    end
  end

  // ****************************************
  // Write response valid
  // ****************************************
  // Raised on the edge that updates the register, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Write response code
  // ****************************************
  // An unmapped address changes nothing and is refused with an error code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= `PSRC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= wr_hit_any ? `PSRC_RESP_OKAY : `PSRC_RESP_SLVERR;
    end
  end

  // ****************************************
  // Read address decode
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit_first = s_axi_araddr[`PSRC_ADDR_W-1:2] == OFS_FIRST[`PSRC_ADDR_W-1:2];
  assign rd_hit_second = s_axi_araddr[`PSRC_ADDR_W-1:2] == OFS_SECOND[`PSRC_ADDR_W-1:2];

  // ****************************************
  // Read data select
  // ****************************************
  // Reserved bits are never stored, so they read zero
  always_comb begin
    rd_word = 32'h00000000;
    rd_resp = `PSRC_RESP_OKAY;
    if (rd_hit_first) begin
      rd_word = ctrl_first_r;
    end else if (rd_hit_second) begin
      rd_word = ctrl_second_r;
    end else begin
      rd_resp = `PSRC_RESP_SLVERR;
    end
  end

  // ****************************************
  // Read response valid
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Read data and code
  // ****************************************
  // Captured once per read and held while rvalid stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= `PSRC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end
  end

  // ****************************************
  // Peripheral reset outputs
  // ****************************************
  // Each line follows its stored bit: high holds the unit in reset
  always_comb begin
    periph_reset.converter = ctrl_first_r[`PSRC_B1_CONVERTER];
    periph_reset.hibernation = ctrl_first_r[`PSRC_B1_HIBERNATION];
    periph_reset.watchdog = ctrl_first_r[`PSRC_B1_WATCHDOG];
    periph_reset.comparator = ctrl_second_r[`PSRC_B2_COMPARATOR];
    periph_reset.counter_two = ctrl_second_r[`PSRC_B2_COUNTER_TWO];
    periph_reset.counter_one = ctrl_second_r[`PSRC_B2_COUNTER_ONE];
    periph_reset.counter_zero = ctrl_second_r[`PSRC_B2_COUNTER_ZERO];
    periph_reset.two_wire = ctrl_second_r[`PSRC_B2_TWO_WIRE];
    periph_reset.sync_serial = ctrl_second_r[`PSRC_B2_SYNC_SERIAL];
    periph_reset.async_second = ctrl_second_r[`PSRC_B2_ASYNC_SECOND];
    periph_reset.async_first = ctrl_second_r[`PSRC_B2_ASYNC_FIRST];
  end

endmodule : psrc_ctrl
`default_nettype wire

// [psrc_ctrl_assertions.sv]
// Assertion checker for the peripheral soft reset controller
`timescale 1ns/1ps
`default_nettype none
`include "psrc_regs.svh"
module psrc_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`PSRC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] capability_mask_first,
  input wire logic [31:0] capability_mask_second,
  input wire psrc_pkg::psrc_resets_t periph_reset
);
  logic [31:0] img1;
  logic [31:0] img2;
  logic ar_t;
  assign img1 = {15'h0000, periph_reset[10], 9'h000, periph_reset[9], 2'h0, periph_reset[8], 3'h0};
  assign img2 = {7'h00, periph_reset[7], 5'h00, periph_reset[6:4], 3'h0, periph_reset[3],
                 7'h00, periph_reset[2], 2'h0, periph_reset[1:0]};
  assign ar_t = s_axi_arvalid && s_axi_arready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_ZERO: assert property (!$past(aresetn) |-> periph_reset == '0)
    else $error("outputs not clear after reset");
  AST_RD_FIRST: assert property (
    ar_t && s_axi_araddr[11:2] == 10'h010 |=> s_axi_rdata == $past(img1))
    else $error("first register read differs from outputs");
  AST_RD_SECOND: assert property (
    ar_t && s_axi_araddr[11:2] == 10'h011 |=> s_axi_rdata == $past(img2))
    else $error("second register read differs from outputs");
  AST_HOLD: assert property (
    $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(periph_reset))
    else $error("outputs changed without a write");
  AST_CAP_FIRST: assert property ($rose(s_axi_bvalid) |->
    ((img1 ^ $past(img1)) & ~$past(capability_mask_first)) == 32'h00000000)
    else $error("absent first unit changed");
  AST_CAP_SECOND: assert property ($rose(s_axi_bvalid) |->
    ((img2 ^ $past(img2)) & ~$past(capability_mask_second)) == 32'h00000000)
    else $error("absent second unit changed");
  AST_R_LAT: assert property (ar_t |=> s_axi_rvalid)
    else $error("read answer late");
  AST_UNMAP: assert property (ar_t && s_axi_araddr[11:3] != 9'h008 |=>
    s_axi_rdata == 32'h00000000 && s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  cover property ($rose(s_axi_bvalid) && s_axi_bresp == 2'h2);
  cover property (ar_t && s_axi_araddr[11:2] == 10'h011);
  cover property ($rose(s_axi_bvalid) && capability_mask_first != 32'hFFFFFFFF);
endmodule : psrc_ctrl_chk
bind psrc_ctrl psrc_ctrl_chk u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp),
  .capability_mask_first(capability_mask_first),
  .capability_mask_second(capability_mask_second),
  .periph_reset(periph_reset)
);
`default_nettype wire

// [psrc_pkg.sv]
// Types shared by the peripheral soft reset controller
`default_nettype none
package psrc_pkg;
  typedef struct packed {
    logic converter;
    logic hibernation;
    logic watchdog;
    logic comparator;
    logic counter_two;
    logic counter_one;
    logic counter_zero;
    logic two_wire;
    logic sync_serial;
    logic async_second;
    logic async_first;
  } psrc_resets_t;
endpackage : psrc_pkg
`default_nettype wire

// [psrc_regs.svh]
// Register map, field positions and reset values of the peripheral soft reset controller
// Behaviour
// - Writes to first control ignore bits whose first capability bit shows absence.
// - Writes to second control ignore bits whose second capability bit shows absence.
// - Both control registers reset to all zeros; no peripheral held after power-up.
// - First register bit 16 is read/write and resets the converter unit.
// - First register bit 6 is read/write and resets the hibernation unit.
// - First register bit 3 is read/write and resets the watchdog unit.
// - Second register bits 18, 17, 16 reset timers two, one, zero.
// - Second register bit 1 is read/write and resets the second serial unit.
// - Second register bit 0 is read/write and resets the first serial unit.
// - Reserved bits read zero and ignore writes; software preserves them.
`ifndef PSRC_REGS_SVH
`define PSRC_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define PSRC_OFS_CTRL_FIRST 12'h040
`define PSRC_OFS_CTRL_SECOND 12'h044
`define PSRC_ADDR_W 12

// ****************************************
// Reset values and defined-bit masks
// ****************************************
`define PSRC_RST_CTRL 32'h00000000
`define PSRC_DEF_FIRST 32'h00010048
`define PSRC_DEF_SECOND 32'h01071013

// ****************************************
// Field positions
// ****************************************
`define PSRC_B1_CONVERTER 16
`define PSRC_B1_HIBERNATION 6
`define PSRC_B1_WATCHDOG 3
`define PSRC_B2_COMPARATOR 24
`define PSRC_B2_COUNTER_TWO 18
`define PSRC_B2_COUNTER_ONE 17
`define PSRC_B2_COUNTER_ZERO 16
`define PSRC_B2_TWO_WIRE 12
`define PSRC_B2_SYNC_SERIAL 4
`define PSRC_B2_ASYNC_SECOND 1
`define PSRC_B2_ASYNC_FIRST 0

`define PSRC_RESP_OKAY 2'h0
`define PSRC_RESP_SLVERR 2'h2

`endif

// [tb_psrc.sv]
// Self-checking bench for the peripheral soft reset controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, wa;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
  logic [31:0] capability_mask_first = 32'hFFFFFFFF, capability_mask_second = 32'hFFFFFFFF;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  psrc_pkg::psrc_resets_t periph_reset;
  int n_errors = 0, n_compared = 0, cyc = 0;
  int pos[11] = '{16, 6, 3, 24, 18, 17, 16, 12, 4, 1, 0};
  psrc_ctrl dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .capability_mask_first(capability_mask_first),
    .capability_mask_second(capability_mask_second),
    .periph_reset(periph_reset)
  );
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic ar, v;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
    chk(d, e);
  endtask : rc
  task automatic test_done();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h040, 32'h00000000);
    chk({30'h0, r}, 32'h0);
    rc(12'h044, 32'h00000000);
    chk({21'h0, periph_reset}, 32'h0);
    $display("reset test done");
    wr(12'h040, 32'hFFFFFFFF, 4'hF);
    chk({30'h0, r}, 32'h0);
    wr(12'h044, 32'hFFFFFFFF, 4'hF);
    rc(12'h040, 32'h00010048);
    rc(12'h044, 32'h01071013);
    chk({21'h0, periph_reset}, 32'h7FF);
    capability_mask_first <= 32'hFFFFFFF7;
    capability_mask_second <= 32'hFFFFFFFE;
    wr(12'h040, 32'h00000000, 4'hF);
    wr(12'h044, 32'h00000000, 4'hF);
    rc(12'h040, 32'h00000008);
    rc(12'h044, 32'h00000001);
    capability_mask_first <= 32'h00000000;
    wr(12'h040, 32'hFFFFFFFF, 4'hF);
    rc(12'h040, 32'h00000008);
    capability_mask_first <= 32'hFFFFFFFF;
    capability_mask_second <= 32'hFFFFFFFF;
    wr(12'h040, 32'hFFFFFFFF, 4'h4);
    rc(12'h040, 32'h00010008);
    $display("mask test done");
    wr(12'h048, 32'hFFFFFFFF, 4'hF);
    chk({30'h0, r}, 32'h2);
    rc(12'h048, 32'h00000000);
    chk({30'h0, r}, 32'h2);
    $display("unmapped test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h040, 32'h00000000);
    rc(12'h044, 32'h00000000);
    $display("second reset test done");
    for (int i = 0; i < 11; i++) begin
      wa = i < 3 ? 12'h040 : 12'h044;
      wr(wa, 32'h1 << pos[i], 4'hF);
      rc(wa, 32'h1 << pos[i]);
      chk({21'h0, periph_reset}, 32'h400 >> i);
      wr(wa, 32'h00000000, 4'hF);
      chk({21'h0, periph_reset}, 32'h0);
    end
    $display("bit walk test done");
    test_done();
  end
endmodule : tb
`default_nettype wire
